//--- hdl/dual_timer_counter.sv
// Two timer/counters with four modes, behind a classic Wishbone register slave.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter #(
    parameter int ADDR_W = 10
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              first_event_pin_i,
    input  wire logic              second_event_pin_i,
    input  wire logic              first_gate_pin_i,
    input  wire logic              second_gate_pin_i,
    input  wire logic [1:0]        vector_ack_i,
    output logic                   first_timer_irq_o,
    output logic                   second_timer_irq_o,
    output logic                   baud_tick_o,
    output logic                   irq_o
);
    import tmr_pkg::*;

    logic [7:0]  control_r;
    logic [7:0]  mode_r;
    logic [7:0]  first_low_r;
    logic [7:0]  first_high_r;
    logic [7:0]  second_low_r;
    logic [7:0]  second_high_r;
    logic [7:0]  aux_r;
    logic [7:0]  irq_enable_r;
    logic [1:0]  event_status_r;
    logic [1:0]  event_mask_r;

    logic [7:0]  first_low_nxt;
    logic [7:0]  first_high_nxt;
    logic [7:0]  second_low_nxt;
    logic [7:0]  second_high_nxt;
    logic        first_flag_nxt;
    logic        second_flag_nxt;
    logic [1:0]  event_status_nxt;

    logic [7:0]  reg_idx;
    logic        bus_req;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;

    timer_cfg_t  first_cfg;
    timer_cfg_t  second_cfg;
    logic        split;
    logic        prescale_tick;
    logic        first_rate;
    logic        second_rate;
    logic        first_edge;
    logic        second_edge;
    logic        first_inc;
    logic        first_high_inc;
    logic        second_inc;
    logic        second_enable;
    count_step_t first_step;
    count_step_t second_step;
    logic        first_ovf;
    logic        first_high_ovf;
    logic        second_ovf;
    logic        set_first_flag;
    logic        set_second_flag;

    // Register bus decode.

    assign reg_idx = wb_adr_i[9:2];
    assign bus_req = wb_cyc_i & wb_stb_i;
    // A write lands on the edge where the master sees the acknowledge, never earlier.
    assign wr_en   = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign wr_data = wb_dat_i[7:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req & ~wb_ack_o;
    end

    always_comb
    begin
        case (reg_idx)
            IDX_CONTROL:      rd_data = control_r;
            IDX_MODE:         rd_data = mode_r;
            IDX_FIRST_LOW:    rd_data = first_low_r;
            IDX_SECOND_LOW:   rd_data = second_low_r;
            IDX_FIRST_HIGH:   rd_data = first_high_r;
            IDX_SECOND_HIGH:  rd_data = second_high_r;
            IDX_AUX:          rd_data = aux_r & AUX_READ_MASK;
            IDX_IRQ_ENABLE:   rd_data = irq_enable_r;
            IDX_EVENT_STATUS: rd_data = {6'h00, event_status_r};
            IDX_EVENT_MASK:   rd_data = {6'h00, event_mask_r};
            default:          rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_req && !wb_ack_o)
            wb_dat_o <= {24'h00_0000, rd_data};
    end

    // Rate generation and event sampling.

    rate_gen #(
        .DIV (PRESCALE)
    ) u_rate (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (prescale_tick)
    );

    assign first_rate  = aux_r[AUX_FIRST_FULL]  | prescale_tick;
    assign second_rate = aux_r[AUX_SECOND_FULL] | prescale_tick;

    event_edge u_first_edge (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sample_i (first_rate),
        .pin_i    (first_event_pin_i),
        .count_o  (first_edge)
    );

    event_edge u_second_edge (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sample_i (second_rate),
        .pin_i    (second_event_pin_i),
        .count_o  (second_edge)
    );

    // Count enables and next values.

    assign first_cfg  = timer_cfg_t'(mode_r[3:0]);
    assign second_cfg = timer_cfg_t'(mode_r[7:4]);
    assign split      = (first_cfg.mode == MODE_SPLIT);

    assign first_inc = control_r[CTRL_FIRST_RUN]
                     & (~first_cfg.gate | first_gate_pin_i)
                     & (first_cfg.count_select ? first_edge : first_rate);

    // In split mode the upper byte of the first timer is a plain timer on the second run bit.
    assign first_high_inc = split & control_r[CTRL_SECOND_RUN] & first_rate;

    // While the first timer is split, the second one has lost its run bit and runs freely.
    assign second_enable = split | control_r[CTRL_SECOND_RUN];
    assign second_inc    = second_enable
                         & (~second_cfg.gate | second_gate_pin_i)
                         & (second_cfg.count_select ? second_edge : second_rate)
                         & (second_cfg.mode != MODE_SPLIT);

    assign first_step  = count_step(first_cfg.mode, first_low_r, first_high_r);
    assign second_step = count_step(second_cfg.mode, second_low_r, second_high_r);

    assign first_ovf      = first_inc & first_step.ovf;
    assign first_high_ovf = first_high_inc & (&first_high_r);
    assign second_ovf     = second_inc & second_step.ovf;
    assign set_first_flag  = first_ovf;
    assign set_second_flag = first_high_ovf | (second_ovf & ~split);

    always_comb
    begin
        first_low_nxt  = first_low_r;
        first_high_nxt = first_high_r;
        if (first_inc)
        begin
            first_low_nxt = first_step.low;
            if (!split)
                first_high_nxt = first_step.high;
        end
        if (first_high_inc)
            first_high_nxt = first_high_r + 8'h01;
    end

    always_comb
    begin
        second_low_nxt  = second_low_r;
        second_high_nxt = second_high_r;
        if (second_inc)
        begin
            second_low_nxt  = second_step.low;
            second_high_nxt = second_step.high;
        end
    end

    // Count bytes: a bus write in the same cycle overrides the increment.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            first_low_r <= REG_RESET;
        else if (wr_en && reg_idx == IDX_FIRST_LOW)
            first_low_r <= wr_data;
        else
            first_low_r <= first_low_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            first_high_r <= REG_RESET;
        else if (wr_en && reg_idx == IDX_FIRST_HIGH)
            first_high_r <= wr_data;
        else
            first_high_r <= first_high_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            second_low_r <= REG_RESET;
        else if (wr_en && reg_idx == IDX_SECOND_LOW)
            second_low_r <= wr_data;
        else
            second_low_r <= second_low_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            second_high_r <= REG_RESET;
        else if (wr_en && reg_idx == IDX_SECOND_HIGH)
            second_high_r <= wr_data;
        else
            second_high_r <= second_high_nxt;
    end

    // Control byte: overflow flags give a hardware set priority over any clear in the same cycle.

    always_comb
    begin
        first_flag_nxt  = control_r[CTRL_FIRST_FLAG];
        second_flag_nxt = control_r[CTRL_SECOND_FLAG];
        if (wr_en && reg_idx == IDX_CONTROL)
        begin
            first_flag_nxt  = wr_data[CTRL_FIRST_FLAG];
            second_flag_nxt = wr_data[CTRL_SECOND_FLAG];
        end
        if (vector_ack_i[0])
            first_flag_nxt = 1'b0;
        if (vector_ack_i[1])
            second_flag_nxt = 1'b0;
        if (set_first_flag)
            first_flag_nxt = 1'b1;
        if (set_second_flag)
            second_flag_nxt = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            control_r <= REG_RESET;
        else
        begin
            if (wr_en && reg_idx == IDX_CONTROL)
            begin
                control_r[CTRL_SECOND_RUN] <= wr_data[CTRL_SECOND_RUN];
                control_r[CTRL_FIRST_RUN]  <= wr_data[CTRL_FIRST_RUN];
                control_r[3:0]             <= wr_data[3:0];
            end
            control_r[CTRL_FIRST_FLAG]  <= first_flag_nxt;
            control_r[CTRL_SECOND_FLAG] <= second_flag_nxt;
        end
    end

    // Plain configuration registers.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_r <= REG_RESET;
        else if (wr_en && reg_idx == IDX_MODE)
            mode_r <= wr_data;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            aux_r <= REG_RESET;
        else if (wr_en && reg_idx == IDX_AUX)
            aux_r <= wr_data & AUX_READ_MASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_enable_r <= REG_RESET;
        else if (wr_en && reg_idx == IDX_IRQ_ENABLE)
            irq_enable_r <= wr_data;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            event_mask_r <= 2'b00;
        else if (wr_en && reg_idx == IDX_EVENT_MASK)
            event_mask_r <= wr_data[1:0];
    end

    // Sticky event status, cleared by writing ones; a new event wins over the clear.

    always_comb
    begin
        event_status_nxt = event_status_r;
        if (wr_en && reg_idx == IDX_EVENT_STATUS)
            event_status_nxt = event_status_r & ~wr_data[1:0];
        if (set_first_flag)
            event_status_nxt[EV_FIRST] = 1'b1;
        if (set_second_flag)
            event_status_nxt[EV_SECOND] = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            event_status_r <= 2'b00;
        else
            event_status_r <= event_status_nxt;
    end

    // Interrupt and baud outputs, all registered, so each lags its cause by one clock.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            first_timer_irq_o  <= 1'b0;
            second_timer_irq_o <= 1'b0;
            baud_tick_o        <= 1'b0;
            irq_o              <= 1'b0;
        end
        else
        begin
            first_timer_irq_o  <= control_r[CTRL_FIRST_FLAG] & irq_enable_r[IEN_FIRST]
                                & irq_enable_r[IEN_GLOBAL];
            second_timer_irq_o <= control_r[CTRL_SECOND_FLAG] & irq_enable_r[IEN_SECOND]
                                & irq_enable_r[IEN_GLOBAL];
            baud_tick_o        <= second_ovf;
            irq_o              <= |(event_status_r & event_mask_r);
        end
    end

endmodule
`default_nettype wire

//--- include/tmr_pkg.sv
// Constants, types and the count step function shared by the dual timer/counter.
// What this block does
// - timer function counts once per twelve clocks
// - counter samples event pin each rate cycle
// - edge count lands one rate cycle later
// - mode zero is thirteen bits, flags wrap
// - count needs run bit and gate; split first high byte skips gate, second its run bit
// - mode one is full sixteen bits
// - mode two reloads low from high byte
// - second timer in mode three holds count
// - split mode: two bytes, high uses second's controls
// - mode register nibbles, codes 00 01 10 11
// - count select picks clock or event pin
// - flags set on overflow, vectoring or software clears
// - full rate bit selects clock or clock/12
// - four count bytes read/write, reset zero
// - second timer overflow drives baud tick
// - flag raises interrupt through enable bits
package tmr_pkg;

    localparam int          PRESCALE         = 12;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [7:0]  IDX_CONTROL      = 8'h88;
    localparam logic [7:0]  IDX_MODE         = 8'h89;
    localparam logic [7:0]  IDX_FIRST_LOW    = 8'h8A;
    localparam logic [7:0]  IDX_SECOND_LOW   = 8'h8B;
    localparam logic [7:0]  IDX_FIRST_HIGH   = 8'h8C;
    localparam logic [7:0]  IDX_SECOND_HIGH  = 8'h8D;
    localparam logic [7:0]  IDX_AUX          = 8'h8E;
    localparam logic [7:0]  IDX_IRQ_ENABLE   = 8'h90;
    localparam logic [7:0]  IDX_VECTOR_ACK   = 8'h91;
    localparam logic [7:0]  IDX_EVENT_STATUS = 8'h92;
    localparam logic [7:0]  IDX_EVENT_MASK   = 8'h93;
    localparam int          CTRL_SECOND_FLAG = 7;
    localparam int          CTRL_SECOND_RUN  = 6;
    localparam int          CTRL_FIRST_FLAG  = 5;
    localparam int          CTRL_FIRST_RUN   = 4;
    localparam int          AUX_FIRST_FULL   = 7;
    localparam int          AUX_SECOND_FULL  = 6;
    localparam logic [7:0]  AUX_READ_MASK    = 8'hFC;
    localparam int          IEN_GLOBAL       = 7;
    localparam int          IEN_SECOND       = 3;
    localparam int          IEN_FIRST        = 1;
    localparam int          EV_FIRST         = 0;
    localparam int          EV_SECOND        = 1;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } timer_mode_t;

    typedef struct packed {
        logic        gate;
        logic        count_select;
        timer_mode_t mode;
    } timer_cfg_t;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic       ovf;
    } count_step_t;

    function automatic count_step_t count_step(input timer_mode_t mode, input logic [7:0] low,
                                               input logic [7:0] high);
        count_step_t s;
        logic [12:0] c13;
        logic [15:0] c16;
        s   = {low, high, 1'b0};
        c13 = {high, low[4:0]} + 13'h0001;
        c16 = {high, low} + 16'h0001;
        case (mode)
            MODE_13BIT:
            begin
                s.high = c13[12:5];
                s.low  = {low[7:5], c13[4:0]};
                s.ovf  = &{high, low[4:0]};
            end
            MODE_16BIT:
            begin
                s.high = c16[15:8];
                s.low  = c16[7:0];
                s.ovf  = &{high, low};
            end
            MODE_RELOAD:
            begin
                s.low  = (&low) ? high : low + 8'h01;
                s.ovf  = &low;
            end
            default:
            begin
                s.low  = low + 8'h01;
                s.ovf  = &low;
            end
        endcase
        return s;
    endfunction

endpackage

//--- hdl/rate_gen.sv
// Free running prescaler that pulses once every DIV clocks.
`timescale 1ns/100ps
`default_nettype none
module rate_gen #(
    parameter int DIV = tmr_pkg::PRESCALE
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    import tmr_pkg::*;

    localparam int                 CW   = $clog2(DIV);
    localparam logic [CW-1:0]      LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || cnt_r == LAST)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + CW'(1);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tick_o <= 1'b0;
        else
            tick_o <= (cnt_r == LAST);
    end
endmodule
`default_nettype wire

//--- hdl/event_edge.sv
// Samples an event pin on each rate tick and flags a seen high-to-low step.
`timescale 1ns/100ps
`default_nettype none
module event_edge (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic sample_i,
    input  wire logic pin_i,
    output logic      count_o
);
    import tmr_pkg::*;

    logic cur_r;
    logic prev_r;

    // Both samples are taken on rate ticks only, so a pulse shorter than one rate cycle can be missed.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur_r  <= 1'b0;
            prev_r <= 1'b0;
        end
        else if (sample_i)
        begin
            cur_r  <= pin_i;
            prev_r <= cur_r;
        end
    end

    // The step is seen after a sample; the count follows on the next rate tick.
    assign count_o = sample_i & prev_r & ~cur_r;
endmodule
`default_nettype wire

//--- sim/dual_timer_counter_sva.sv
// Checker for the register bus and interrupt output of the dual timer/counter.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_sva
    import tmr_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              irq_o
);
    logic [7:0] mode_r;
    logic [7:0] aux_r;
    logic [7:0] mask_r;
    logic [7:0] idx;
    logic       wr_ack;
    logic       rd_ack;
    assign idx = wb_adr_i[9:2];
    assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_ack = wb_ack_o && !wb_we_i;
    // Shadows of registers only software changes, so reads are fully predictable.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_r <= 8'h00;
            aux_r <= 8'h00;
            mask_r <= 8'h00;
        end
        else if (wr_ack)
        begin
            if (idx == IDX_MODE)
                mode_r <= wb_dat_i[7:0];
            if (idx == IDX_AUX)
                aux_r <= wb_dat_i[7:0];
            if (idx == IDX_EVENT_MASK)
                mask_r <= {6'h00, wb_dat_i[1:0]};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without a request");
    read_upper_a: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    unmapped_zero_a: assert property (rd_ack && idx == IDX_VECTOR_ACK |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    mode_hold_a: assert property (rd_ack && idx == IDX_MODE |-> wb_dat_o[7:0] == mode_r)
        else $error("mode register lost its value");
    aux_bits_a: assert property (rd_ack && idx == IDX_AUX |-> wb_dat_o[7:0] == {aux_r[7:2], 2'b00})
        else $error("auxiliary register read wrong");
    irq_masked_a: assert property ($past(mask_r) == 8'h00 |-> !irq_o)
        else $error("interrupt while fully masked");
    reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o)
        else $error("outputs not quiet after reset");
    cover property (wr_ack && idx == IDX_MODE);
    cover property (rd_ack && idx == IDX_AUX);
    cover property (irq_o);
endmodule
bind dual_timer_counter dual_timer_counter_sva #(.ADDR_W(ADDR_W)) i_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire

//--- sim/pin_partner.sv
// Model of the external event and gate pins that feed one timer.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic [3:0] pulses_i,
    input  wire logic       gate_i,
    output logic            event_o,
    output logic            gate_o,
    output logic            busy_o
);
    int left = 0;
    int ph = 0;
    initial event_o = 1'b1;
    initial gate_o = 1'b0;
    initial busy_o = 1'b0;
    // Each level stands 30 clocks, longer than a prescaled rate cycle, so every level is sampled.
    always @(posedge clk_i)
    begin
        gate_o <= gate_i;
        ph = ph + 1;
        if (start_i && !busy_o)
        begin
            left = pulses_i;
            ph = 0;
            busy_o <= 1'b1;
        end
        else if (busy_o && ph >= 30)
        begin
            ph = 0;
            event_o <= !event_o;
            if (!event_o)
                left = left - 1;
            busy_o <= event_o || left != 0;
        end
    end
endmodule
`default_nettype wire

//--- sim/dual_timer_counter_bench.sv
// Self-checking bench for the dual timer/counter.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_bench;
    import tmr_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  wsel = 4'h1;
    logic [31:0] rdat;
    logic        ack;
    logic [1:0]  vack = 2'b00;
    logic [1:0]  start = 2'b00;
    logic [3:0]  npul = 4'h1;
    logic [1:0]  greq = 2'b00;
    logic [1:0]  ev;
    logic [1:0]  gp;
    logic [1:0]  busy;
    logic        irq0;
    logic        irq1;
    logic        baud;
    logic        irq;
    logic [31:0] lfsr = 32'h0000_54b7;
    int          fail_count = 0;
    int          n_compared = 0;
    always #25 clk_i = ~clk_i;
    dual_timer_counter i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .first_event_pin_i(ev[0]),
        .second_event_pin_i(ev[1]), .first_gate_pin_i(gp[0]), .second_gate_pin_i(gp[1]),
        .vector_ack_i(vack), .first_timer_irq_o(irq0), .second_timer_irq_o(irq1), .baud_tick_o(baud),
        .irq_o(irq));
    pin_partner i_p0 (.clk_i(clk_i), .start_i(start[0]), .pulses_i(npul), .gate_i(greq[0]),
        .event_o(ev[0]), .gate_o(gp[0]), .busy_o(busy[0]));
    pin_partner i_p1 (.clk_i(clk_i), .start_i(start[1]), .pulses_i(npul), .gate_i(greq[1]),
        .event_o(ev[1]), .gate_o(gp[1]), .busy_o(busy[1]));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= {a, 2'b00};
        wdat <= {24'h00_0000, d};
        // Only the watchdog ends a wait for the acknowledge.
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic ex(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(a, 1'b0, 8'h00, q);
        check(q, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        tick(20000);
        fail_count++;
        complete_run();
    end
    initial
    begin
        logic [7:0] q;
        int         k;
        tick(3);
        rst_i <= 1'b0;
        for (k = 8'h88; k <= 8'h8E; k++)
            ex(k[7:0], 8'h00);
        ex(IDX_VECTOR_ACK, 8'h00);
        for (k = 0; k < 4; k++)
        begin
            lfsr = lfsr_next(lfsr);
            wr(IDX_FIRST_LOW + k[7:0], lfsr[7:0]);
            ex(IDX_FIRST_LOW + k[7:0], lfsr[7:0]);
        end
        wr(IDX_AUX, 8'hFF);
        ex(IDX_AUX, 8'hFC);
        wr(IDX_MODE, 8'h01);
        wr(IDX_FIRST_HIGH, 8'hFF);
        wr(IDX_FIRST_LOW, 8'hF0);
        wr(IDX_CONTROL, 8'h10);
        tick(40);
        ex(IDX_CONTROL, 8'h30);
        ex(IDX_EVENT_STATUS, 8'h01);
        wr(IDX_FIRST_LOW, 8'h40);
        ex(IDX_FIRST_LOW, 8'h41);
        check({7'h00, irq}, 8'h00);
        wr(IDX_EVENT_MASK, 8'h01);
        tick(2);
        check({7'h00, irq}, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h82);
        tick(2);
        check({7'h00, irq0}, 8'h01);
        vack <= 2'b01;
        tick(1);
        vack <= 2'b00;
        tick(2);
        check({7'h00, irq0}, 8'h00);
        ex(IDX_CONTROL, 8'h10);
        wr(IDX_CONTROL, 8'h00);
        ex(IDX_FIRST_HIGH, 8'h00);
        wr(IDX_EVENT_STATUS, 8'h01);
        tick(2);
        check({7'h00, irq}, 8'h00);
        wr(IDX_MODE, 8'h00);
        wr(IDX_FIRST_HIGH, 8'hFF);
        wr(IDX_FIRST_LOW, 8'hFD);
        wr(IDX_CONTROL, 8'h10);
        tick(20);
        ex(IDX_CONTROL, 8'h30);
        wr(IDX_CONTROL, 8'h00);
        ex(IDX_FIRST_HIGH, 8'h00);
        bus(IDX_FIRST_LOW, 1'b0, 8'h00, q);
        check(8'(q[7:5]), 8'h07);
        wr(IDX_MODE, 8'h02);
        wr(IDX_FIRST_HIGH, 8'hF0);
        wr(IDX_FIRST_LOW, 8'hFE);
        wr(IDX_CONTROL, 8'h10);
        tick(40);
        ex(IDX_CONTROL, 8'h30);
        wr(IDX_CONTROL, 8'h00);
        ex(IDX_FIRST_HIGH, 8'hF0);
        bus(IDX_FIRST_LOW, 1'b0, 8'h00, q);
        check(8'(q[7:4]), 8'h0F);
        wr(IDX_AUX, 8'h00);
        wr(IDX_MODE, 8'h01);
        wr(IDX_FIRST_HIGH, 8'h00);
        wr(IDX_FIRST_LOW, 8'h00);
        wr(IDX_CONTROL, 8'h10);
        tick(240);
        wr(IDX_CONTROL, 8'h00);
        bus(IDX_FIRST_LOW, 1'b0, 8'h00, q);
        check(8'(q >= 8'd20 && q <= 8'd21), 8'h01);
        wr(IDX_MODE, 8'h05);
        wr(IDX_FIRST_LOW, 8'h00);
        wr(IDX_CONTROL, 8'h10);
        lfsr = lfsr_next(lfsr);
        npul <= {1'b0, lfsr[2:0]} + 4'h1;
        start <= 2'b01;
        tick(1);
        start <= 2'b00;
        tick(2);
        for (k = 0; busy[0] !== 1'b0 && k < 2000; k++)
            tick(1);
        tick(40);
        wr(IDX_CONTROL, 8'h00);
        ex(IDX_FIRST_LOW, {4'h0, npul});
        wr(IDX_AUX, 8'h40);
        wr(IDX_MODE, 8'h90);
        wr(IDX_SECOND_LOW, 8'h00);
        wr(IDX_CONTROL, 8'h40);
        tick(30);
        ex(IDX_SECOND_LOW, 8'h00);
        greq <= 2'b10;
        tick(30);
        bus(IDX_SECOND_LOW, 1'b0, 8'h00, q);
        check(8'(q != 8'h00), 8'h01);
        wr(IDX_SECOND_HIGH, 8'hFF);
        wr(IDX_SECOND_LOW, 8'hF0);
        for (k = 0; baud !== 1'b1 && k < 80; k++)
            tick(1);
        check({7'h00, baud}, 8'h01);
        ex(IDX_CONTROL, 8'hC0);
        wr(IDX_IRQ_ENABLE, 8'h88);
        tick(2);
        check({7'h00, irq1}, 8'h01);
        vack <= 2'b10;
        tick(1);
        vack <= 2'b00;
        ex(IDX_CONTROL, 8'h40);
        wr(IDX_MODE, 8'h30);
        bus(IDX_SECOND_LOW, 1'b0, 8'h00, q);
        tick(20);
        ex(IDX_SECOND_LOW, q);
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_MODE, 8'h33);
        wr(IDX_AUX, 8'h80);
        wr(IDX_FIRST_LOW, 8'h5A);
        wr(IDX_FIRST_HIGH, 8'hFE);
        wr(IDX_CONTROL, 8'h40);
        tick(20);
        ex(IDX_CONTROL, 8'hC0);
        ex(IDX_FIRST_LOW, 8'h5A);
        wsel = 4'h2;
        wr(IDX_MODE, 8'h00);
        wsel = 4'h1;
        ex(IDX_MODE, 8'h33);
        complete_run();
    end
endmodule
`default_nettype wire
